/* core/iecb_pkg.sv */
// Shared constants and carriers for the event capture bank
package iecb_pkg;

  // Bus and register widths
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 32'h0001_D300;  // Soft reset control
  localparam logic [ADDR_W-1:0] OFF_EVENT  = 32'h0001_D304;  // Sticky event status
  localparam logic [ADDR_W-1:0] OFF_FRESH  = 32'h0001_D308;  // Fresh event capture
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 32'h0001_D30C;  // Event enable mask
  localparam logic [ADDR_W-1:0] OFF_INTST  = 32'h0001_D310;  // Interrupt status snapshot

  // Event bit positions
  localparam int unsigned BIT_BOOT_GOOD  = 23;
  localparam int unsigned BIT_NO_ACK     = 26;
  localparam int unsigned BIT_COLLISION  = 27;
  localparam int unsigned BIT_TXN_TO     = 28;
  localparam int unsigned BIT_BYTE_TO    = 29;
  localparam int unsigned BIT_CLK_LOW_TO = 30;
  localparam int unsigned BIT_ARB_TO     = 31;

  // Soft reset bit in the control word
  localparam int unsigned BIT_SOFT_RESET = 0;

  // Event bits this bank implements; all others are reserved and read zero
  localparam logic [DATA_W-1:0] EVENT_IMPL = 32'hFC80_0000;

  // Reset values
  localparam logic [DATA_W-1:0] EVENT_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] FRESH_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ENABLE_RST = 32'hFC80_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;

  // Cycles to wait after reset release before the strap is trusted
  localparam int unsigned SETTLE_W   = 3;
  localparam logic [SETTLE_W-1:0] SETTLE_CYC = 3'h4;
  localparam logic [SETTLE_W-1:0] SETTLE_ONE = 3'h1;
  localparam logic [SETTLE_W-1:0] SETTLE_RST = 3'h0;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_DEPTH = 3;
  localparam logic [SYNC_DEPTH-1:0] SYNC_RST = 3'h0;

  // Register bus request, one cycle per strobe
  typedef struct packed {
    logic [ADDR_W-1:0] addr;   // Byte address
    logic [DATA_W-1:0] wdata;  // Write data
    logic              wr;     // Write strobe
    logic              rd;     // Read strobe
  } iecb_req_t;

  // Event sources from the master engine and boot sequencer
  typedef struct packed {
    logic sw_txn;       // Software-initiated master transaction active
    logic boot_active;  // Boot load sequence active
    logic past_addr;    // Slave addressing phase is over
    logic boot_good;    // Boot load finished with no error, pulse
    logic no_ack;       // NACK seen from addressed slave, pulse
    logic collision;    // Arbitration lost, pulse
    logic txn_to;       // Transaction timer expired, pulse
    logic byte_to;      // Byte timer expired, pulse
    logic clk_low_to;   // Clock low timer expired, pulse
    logic arb_to;       // Arbitration timer expired, pulse
  } iecb_src_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [DATA_W-1:0]   sticky;      // Sticky event status
    logic [DATA_W-1:0]   fresh;       // Events since last snapshot
    logic [DATA_W-1:0]   enable;      // Enable mask
    logic                soft_reset;  // Controller soft reset
    logic                strap_done;  // Power-up strap handled
    logic [SETTLE_W-1:0] settle;      // Settle counter after reset
    logic [DATA_W-1:0]   rdata;       // Read answer
    logic                irq;         // Interrupt level
  } iecb_state_t;

  // Whole state of the pin synchroniser
  typedef struct packed {
    logic [SYNC_DEPTH-1:0] pipe;   // Three-stage capture chain
    logic                  level;  // Filtered level
  } iecb_sync_t;

endpackage : iecb_pkg

/* core/iecb_pin_sync.sv */
`timescale 1ns/10ps
// Three-stage pin synchroniser with agreement filter
module iecb_pin_sync (
  input  wire logic i_mclk,   // Core clock
  input  wire logic i_rst_n,  // Asynchronous reset, active low
  input  wire logic i_ce,     // Clock enable, freezes state when low
  input  wire logic i_pin,    // Raw pin level
  output logic      o_level   // Filtered level
);
  import iecb_pkg::*;

  iecb_sync_t s_q;  // Registered state
  iecb_sync_t s_d;  // Next state

  // Shift the pin in; the level moves only when stages two and three agree
  always_comb begin
    s_d      = s_q;
    s_d.pipe = {s_q.pipe[SYNC_DEPTH-2:0], i_pin};
    // Stage one feeds stage two only; the filter looks at two and three
    if (s_q.pipe[1] == s_q.pipe[2]) begin
      s_d.level = s_q.pipe[2];
    end
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q.pipe  <= SYNC_RST;
      s_q.level <= 1'b0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;

endmodule : iecb_pin_sync

/* core/iecb_bank.sv */
`timescale 1ns/10ps
// How it works
// RULE1: Boot sequence done cleanly sets boot-good
// RULE2: Boot load disabled at power up sets boot-good
// RULE3: NACK in software master transaction sets bit
// RULE4: NACK, collision, clock-low also set during boot
// RULE5: Arbitration lost after addressing sets collision
// RULE6: Transaction timer expiry in software transaction
// RULE7: Byte timer expiry in software transaction
// RULE8: Clock held low timer expiry sets bit
// RULE9: Arbitration timer expiry sets bit
// RULE10: Fresh register mirrors events since snapshot
// RULE11: Writing one sets fresh bit; zero ignored
// RULE12: Event write or snapshot clears fresh
// RULE13: Soft reset clears and blocks all events
// RULE14: Event register write-one-clear; reserved read zero
// RULE15: Enable bit gates event into interrupt status
module iecb_bank (
  input  wire logic                      i_mclk,         // Core clock, 200 MHz
  input  wire logic                      i_rst_n,        // Asynchronous reset, active low
  input  wire logic                      i_ce,           // Clock enable, freezes state when low
  input  wire iecb_pkg::iecb_req_t       i_req,          // Register bus request
  input  wire iecb_pkg::iecb_src_t       i_src,          // Event sources, same clock
  input  wire logic                      i_boot_off_pin, // Strap: boot load disabled
  output logic [iecb_pkg::DATA_W-1:0]    o_rdata,        // Read data, cycle after read
  output logic                           o_irq,          // Interrupt level, active high
  output logic                           o_soft_reset    // Soft reset level to engines
);
  import iecb_pkg::*;

  iecb_state_t s_q;        // Registered state
  iecb_state_t s_d;        // Next state
  logic        strap_lvl;  // Synchronised strap level

  // Address match for one register word
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  // Place one event flag at its bit position
  function automatic logic [DATA_W-1:0] at_bit(input logic flag,
                                               input int unsigned pos);
    logic [DATA_W-1:0] w;
    w      = ZERO_WORD;
    w[pos] = flag;
    at_bit = w;
  endfunction : at_bit

  // Strap arrives from a pin, so it is synchronised first
  iecb_pin_sync u_strap_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_pin   (i_boot_off_pin),
    .o_level (strap_lvl)
  );

  // Decoded bus strobes
  logic wr_ctrl;    // Write to control word
  logic wr_event;   // Write to sticky event register
  logic wr_fresh;   // Write to fresh capture register
  logic wr_enable;  // Write to enable mask
  logic rd_intst;   // Read of interrupt status, takes a snapshot

  // Strobe decode
  always_comb begin
    wr_ctrl   = i_req.wr && hit(i_req.addr, OFF_CTRL);
    wr_event  = i_req.wr && hit(i_req.addr, OFF_EVENT);
    wr_fresh  = i_req.wr && hit(i_req.addr, OFF_FRESH);
    wr_enable = i_req.wr && hit(i_req.addr, OFF_ENABLE);
    rd_intst  = i_req.rd && hit(i_req.addr, OFF_INTST);
  end

  // Event qualification
  logic              in_master;   // Any master activity, software or boot
  logic              strap_fire;  // Strap says boot load is off
  logic [DATA_W-1:0] hw_set;      // Events raised by hardware this cycle

  // Qualify each source by the transaction it belongs to
  always_comb begin
    in_master  = i_src.sw_txn || i_src.boot_active;
    // Strap only trusted once the settle time has run out
    strap_fire = !s_q.strap_done && (s_q.settle == SETTLE_CYC) && strap_lvl;
    hw_set     = ZERO_WORD;
    // RULE1: clean boot finish
    hw_set     = hw_set | at_bit(i_src.boot_good, BIT_BOOT_GOOD);
    // RULE2: boot disabled strap
    hw_set     = hw_set | at_bit(strap_fire, BIT_BOOT_GOOD);
    // RULE3: NACK in transaction
    // RULE4: also during boot
    hw_set     = hw_set | at_bit(i_src.no_ack && in_master, BIT_NO_ACK);
    // RULE5: collision after addressing
    hw_set     = hw_set | at_bit(i_src.collision && i_src.past_addr && in_master,
                                 BIT_COLLISION);
    // RULE6: transaction timer expiry
    hw_set     = hw_set | at_bit(i_src.txn_to && i_src.sw_txn, BIT_TXN_TO);
    // RULE7: byte timer expiry
    hw_set     = hw_set | at_bit(i_src.byte_to && i_src.sw_txn, BIT_BYTE_TO);
    // RULE8: clock low timer expiry
    // RULE4: clock low during boot
    hw_set     = hw_set | at_bit(i_src.clk_low_to && in_master, BIT_CLK_LOW_TO);
    // RULE9: arbitration timer expiry
    hw_set     = hw_set | at_bit(i_src.arb_to && in_master, BIT_ARB_TO);
  end

  // Read answer for the addressed word
  logic [DATA_W-1:0] rd_word;  // Value for the current read

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rd_word = ZERO_WORD;
    if (hit(i_req.addr, OFF_CTRL)) begin
      rd_word = at_bit(s_q.soft_reset, BIT_SOFT_RESET);
    end else if (hit(i_req.addr, OFF_EVENT)) begin
      // RULE14: reserved bits read zero
      rd_word = s_q.sticky & EVENT_IMPL;
    end else if (hit(i_req.addr, OFF_FRESH)) begin
      rd_word = s_q.fresh & EVENT_IMPL;
    end else if (hit(i_req.addr, OFF_ENABLE)) begin
      rd_word = s_q.enable & EVENT_IMPL;
    end else if (hit(i_req.addr, OFF_INTST)) begin
      // RULE15: enabled events only
      rd_word = s_q.sticky & s_q.enable;
    end
  end

  // Next-state logic for the whole bank
  always_comb begin
    s_d = s_q;

    // Settle counter runs once after reset release, then parks
    if (s_q.settle != SETTLE_CYC) begin
      s_d.settle = s_q.settle + SETTLE_ONE;
    end

    // Strap handled once; held pending while soft reset blocks events
    if (!s_q.strap_done && (s_q.settle == SETTLE_CYC) && !s_q.soft_reset) begin
      s_d.strap_done = 1'b1;
    end

    // Control word write
    if (wr_ctrl) begin
      s_d.soft_reset = i_req.wdata[BIT_SOFT_RESET];
    end

    // Enable mask write
    if (wr_enable) begin
      s_d.enable = i_req.wdata & EVENT_IMPL;
    end

    if (s_q.soft_reset) begin
      // RULE13: clear and block
      s_d.sticky = EVENT_RST;
      s_d.fresh  = FRESH_RST;
    end else begin
      // RULE14: write one clears
      if (wr_event) begin
        s_d.sticky = s_q.sticky & ~(i_req.wdata & EVENT_IMPL);
      end
      // RULE12: clear on write or snapshot
      if (wr_event || rd_intst) begin
        s_d.fresh = FRESH_RST;
      end
      // RULE11: write one sets
      if (wr_fresh) begin
        s_d.fresh = s_d.fresh | (i_req.wdata & EVENT_IMPL);
      end
      // Hardware sets come last, so a set beats a same-cycle clear
      s_d.sticky = s_d.sticky | hw_set;
      // RULE10: fresh mirrors new events
      s_d.fresh  = s_d.fresh | hw_set;
    end

    // Read data stands only in the cycle after the strobe
    s_d.rdata = i_req.rd ? rd_word : ZERO_WORD;

    // RULE15: enable gates interrupt
    s_d.irq = |(s_d.sticky & s_d.enable);
  end

  // State register; reset loads constants only
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q.sticky     <= EVENT_RST;
      s_q.fresh      <= FRESH_RST;
      s_q.enable     <= ENABLE_RST;
      s_q.soft_reset <= 1'b0;
      s_q.strap_done <= 1'b0;
      s_q.settle     <= SETTLE_RST;
      s_q.rdata      <= ZERO_WORD;
      s_q.irq        <= 1'b0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  assign o_rdata      = s_q.rdata;
  assign o_irq        = s_q.irq;
  assign o_soft_reset = s_q.soft_reset;

endmodule : iecb_bank

/* dv/iecb_src_model.sv */
`timescale 1ns/10ps
// Stand-in for the master, slave and boot engines
module iecb_src_model
  import iecb_pkg::*;
(
  input  wire logic       i_mclk,   // Core clock
  input  wire logic       i_rst_n,  // Asynchronous reset, active low
  input  wire logic [6:0] i_fire,   // Pulse request, boot_good first
  input  wire logic [2:0] i_lvl,    // Software, boot and addressing levels
  output iecb_src_t       o_src     // Event sources to the bank
);
  // Registered, so each source follows its request one cycle later and lasts as long as the request
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_src <= '0;
    end else begin
      o_src <= {i_lvl, i_fire};
    end
  end
endmodule : iecb_src_model

/* dv/iecb_bank_sva.sv */
`timescale 1ns/10ps
// Port-level checks of the event capture bank
module iecb_bank_sva
  import iecb_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire iecb_req_t         i_req,
  input  wire iecb_src_t         i_src,
  input  wire logic              i_boot_off_pin,
  input  wire logic [DATA_W-1:0] o_rdata,
  input  wire logic              o_irq,
  input  wire logic              o_soft_reset
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Decoded bus cycles
  wire rd_ev = i_ce & i_req.rd & (i_req.addr == OFF_EVENT);
  wire rd_fr = i_ce & i_req.rd & (i_req.addr == OFF_FRESH);
  wire rd_is = i_ce & i_req.rd & (i_req.addr == OFF_INTST);
  wire wr_ev = i_ce & i_req.wr & (i_req.addr == OFF_EVENT);
  wire wr_fr = i_ce & i_req.wr & (i_req.addr == OFF_FRESH);
  wire live  = i_ce & !o_soft_reset;
  chk_boot_sets: assert property (i_src.boot_good && live ##1 rd_ev && live |=> o_rdata[BIT_BOOT_GOOD])
    else $error("boot good pulse not captured");
  chk_nack_sets: assert property (i_src.no_ack && i_src.sw_txn && live ##1 rd_ev && live |=> o_rdata[BIT_NO_ACK])
    else $error("nack not captured");
  chk_boot_clk_sets: assert property (i_src.clk_low_to && i_src.boot_active && live ##1 rd_ev && live
    |=> o_rdata[BIT_CLK_LOW_TO]) else $error("clock low timeout in boot not captured");
  chk_coll_sets: assert property (i_src.collision && i_src.past_addr && i_src.sw_txn && live ##1 rd_ev && live
    |=> o_rdata[BIT_COLLISION]) else $error("collision not captured");
  chk_txn_sets: assert property (i_src.txn_to && i_src.sw_txn && live ##1 rd_ev && live |=> o_rdata[BIT_TXN_TO])
    else $error("transaction timeout not captured");
  chk_byte_sets: assert property (i_src.byte_to && i_src.sw_txn && live ##1 rd_ev && live |=> o_rdata[BIT_BYTE_TO])
    else $error("byte timeout not captured");
  chk_arb_sets: assert property (i_src.arb_to && i_src.sw_txn && live ##1 rd_ev && live |=> o_rdata[BIT_ARB_TO])
    else $error("arbitration timeout not captured");
  chk_w1s_fresh: assert property (wr_fr && i_req.wdata[BIT_NO_ACK] && live ##1 rd_fr && live
    |=> o_rdata[BIT_NO_ACK]) else $error("fresh write one did not set");
  chk_snap_clear: assert property (rd_is && i_src[6:0] == 7'h00 ##1 rd_fr |=> o_rdata[31:26] == 6'h00)
    else $error("snapshot did not clear fresh");
  chk_w1c_event: assert property (wr_ev && i_req.wdata[BIT_TXN_TO] && !i_src.txn_to ##1 rd_ev
    |=> !o_rdata[BIT_TXN_TO]) else $error("event write one did not clear");
  chk_rsvd_zero: assert property (rd_ev || rd_fr |=> (o_rdata & ~EVENT_IMPL) == ZERO_WORD)
    else $error("reserved bits read nonzero");
  chk_soft_reset_irq: assert property (o_soft_reset && $past(o_soft_reset) |-> !o_irq)
    else $error("interrupt high during soft reset");
  chk_soft_reset_clear: assert property (o_soft_reset && $past(o_soft_reset) && (rd_ev || rd_fr)
    |=> o_rdata == ZERO_WORD) else $error("events seen during soft reset");
endmodule : iecb_bank_sva
bind iecb_bank iecb_bank_sva i_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req),
  .i_src(i_src), .i_boot_off_pin(i_boot_off_pin), .o_rdata(o_rdata), .o_irq(o_irq), .o_soft_reset(o_soft_reset));

/* dv/iecb_bank_tb.sv */
`timescale 1ns/10ps
// Register-level test of the event capture bank
module iecb_bank_tb;
  import iecb_pkg::*;
  logic              mclk            = 1'b0;  // Core clock
  logic              rst_n           = 1'b0;  // Reset, active low
  iecb_req_t         req             = '0;     // Bus request
  iecb_src_t         src;                      // Sources from the model
  logic [6:0]        fire            = 7'h00;  // Pulse request
  logic [2:0]        lvl             = 3'h0;   // Qualifier levels
  logic [DATA_W-1:0] rdata;                    // Read answer
  logic              irq;                      // Interrupt level
  logic              sres;                     // Soft reset level
  logic              ce              = 1'b1;   // Clock enable
  int                failures        = 0;
  int                samples_checked = 0;
  int unsigned       pos [7] = '{BIT_BOOT_GOOD, BIT_NO_ACK, BIT_COLLISION, BIT_TXN_TO, BIT_BYTE_TO,
                                 BIT_CLK_LOW_TO, BIT_ARB_TO};
  logic [2:0]        modes [4] = '{3'h5, 3'h3, 3'h6, 3'h0};  // {sw_txn, boot_active, past_addr}
  always #2.5 mclk = ~mclk;
  iecb_src_model i_src_m (.i_mclk(mclk), .i_rst_n(rst_n), .i_fire(fire), .i_lvl(lvl), .o_src(src));
  // Strap tied high: boot load disabled
  iecb_bank i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_req(req), .i_src(src),
    .i_boot_off_pin(1'b1), .o_rdata(rdata), .o_irq(irq), .o_soft_reset(sres));
  task automatic check(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One bus cycle; strobes stay until the next call replaces them
  task automatic bus(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge mclk);
  endtask : bus
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string nm);
    bus(1'b0, 1'b1, a, ZERO_WORD);
    #1 check(nm, rdata, exp);
  endtask : rd
  // Bus goes idle while the model emits one pulse
  task automatic pulse(input logic [6:0] m, input logic [2:0] l);
    req <= '0;
    fire <= m;
    lvl <= l;
    @(posedge mclk);
    fire <= 7'h00;
    @(posedge mclk);
  endtask : pulse
  // Whether source i may set its bit under levels l
  function automatic logic hit(input int i, input logic [2:0] l);
    case (i)
      0: hit = 1'b1;
      2: hit = l[0] & (l[2] | l[1]);
      3, 4: hit = l[2];
      default: hit = l[2] | l[1];
    endcase
  endfunction : hit
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    final_report();
  end
  initial begin
    logic e;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFF_ENABLE, ENABLE_RST, "enable reset");
    rd(OFF_EVENT, EVENT_RST, "event reset");
    repeat (12) bus(1'b0, 1'b0, ZERO_WORD, ZERO_WORD);
    rd(OFF_FRESH, 32'h0080_0000, "strap fresh");
    rd(OFF_INTST, 32'h0080_0000, "strap status");
    rd(OFF_FRESH, ZERO_WORD, "fresh after snapshot");
    check("irq strap", 32'(irq), 32'h1);
    wr(OFF_EVENT, 32'h0080_0000);
    rd(OFF_EVENT, ZERO_WORD, "event cleared");
    check("irq cleared", 32'(irq), 32'h0);
    $display("reset and strap test done");
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 7; i++) begin
        e = hit(i, modes[m]);
        pulse(7'h40 >> i, modes[m]);
        rd(OFF_EVENT, e ? (32'h1 << pos[i]) : ZERO_WORD, "source event");
        check("irq source", 32'(irq), 32'(e));
        wr(OFF_EVENT, EVENT_IMPL);
      end
    end
    $display("source table test done");
    wr(OFF_FRESH, 32'h0400_0001);
    rd(OFF_FRESH, 32'h0400_0000, "fresh set");
    wr(OFF_FRESH, ZERO_WORD);
    rd(OFF_FRESH, 32'h0400_0000, "fresh zero write");
    wr(OFF_EVENT, ZERO_WORD);
    rd(OFF_FRESH, ZERO_WORD, "fresh after event write");
    rd(32'h0001_D314, ZERO_WORD, "unmapped");
    $display("fresh register test done");
    wr(OFF_ENABLE, ZERO_WORD);
    pulse(7'h20, 3'h4);
    rd(OFF_INTST, ZERO_WORD, "masked status");
    check("irq masked", 32'(irq), 32'h0);
    wr(OFF_ENABLE, 32'h0400_0000);
    rd(OFF_INTST, 32'h0400_0000, "unmasked status");
    check("irq unmasked", 32'(irq), 32'h1);
    wr(OFF_ENABLE, ENABLE_RST);
    $display("enable test done");
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_FRESH, EVENT_IMPL);
    pulse(7'h01, 3'h4);
    rd(OFF_EVENT, ZERO_WORD, "event in soft reset");
    rd(OFF_FRESH, ZERO_WORD, "fresh in soft reset");
    check("irq soft reset", 32'(irq), 32'h0);
    check("soft reset out", 32'(sres), 32'h1);
    wr(OFF_CTRL, ZERO_WORD);
    pulse(7'h01, 3'h4);
    rd(OFF_EVENT, 32'h8000_0000, "event after soft reset");
    wr(OFF_EVENT, EVENT_IMPL);
    rd(OFF_EVENT, ZERO_WORD, "event write one clear");
    $display("soft reset test done");
    // A pulse that lands while the clock enable is low must be lost
    ce <= 1'b0;
    pulse(7'h01, 3'h4);
    ce <= 1'b1;
    rd(OFF_EVENT, ZERO_WORD, "event while frozen");
    $display("clock enable test done");
    final_report();
  end
endmodule : iecb_bank_tb
